// *** core/sfap_pkg.sv ***
`default_nettype none
package sfap_pkg;
   // ----------------------------------------------------------------
   // status register layout
   // ----------------------------------------------------------------
   localparam int STAT_PIN_EN_BIT = 7;
   localparam int STAT_GUARD_HI_BIT = 3;
   localparam int STAT_GUARD_LO_BIT = 2;
   localparam int STAT_LATCH_BIT = 1;
   localparam logic [7:0] STAT_WRITE_MASK = 8'h8C;
   localparam logic [2:0] NV_RESET = 3'h0;
   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_MEM_READ = 8'h03;
   localparam logic [7:0] OP_MEM_WRITE = 8'h02;
   // ----------------------------------------------------------------
   // array geometry and guard ranges
   // ----------------------------------------------------------------
   localparam int ADDR_W = 11;
   localparam int DEPTH = 2048;
   localparam logic [10:0] GUARD_QTR_BASE = 11'h600;
   localparam logic [10:0] GUARD_HALF_BASE = 11'h400;
   localparam logic [10:0] GUARD_ALL_BASE = 11'h000;
   localparam logic [10:0] ADDR_ZERO = 11'h000;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic pinEnable;
      logic guardHi;
      logic guardLo;
   } sfap_nv_t;
   typedef struct packed {
      logic sck;
      logic csN;
      logic mosi;
      logic holdN;
      logic lockN;
   } sfap_pins_t;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'h0,
      ST_ADDR_HI = 3'h1,
      ST_ADDR_LO = 3'h3,
      ST_DATA = 3'h2,
      ST_STATUS = 3'h6,
      ST_IGNORE = 3'h7
   } sfap_state_t;
endpackage : sfap_pkg
`default_nettype wire

// *** core/sfap_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfap_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // pins in, synchronised out
   input wire sfap_pkg::sfap_pins_t pinsIn,
   output var sfap_pkg::sfap_pins_t pinsOut
);
   import sfap_pkg::*;
   sfap_pins_t stage1_q;
   // two-flop synchroniser, idle levels at reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         stage1_q <= 5'h0F;
         pinsOut <= 5'h0F;
      end else begin
         stage1_q <= pinsIn;
         pinsOut <= stage1_q;
      end
   end
endmodule : sfap_sync
`default_nettype wire

// *** core/sfap_fram_access.sv ***
// Function
// (RULE1) status bits 0, 4, 5, 6 read zero and ignore writes
// (RULE2) status: pin enable bit 7, guards bits 3 and 2, latch bit 1
// (RULE3) pin enable and guard bits kept in nonvolatile storage; here sys_rst clears them to zero
// (RULE4) latch set by unlock, cleared by write end or lock command
// (RULE5) guards 00 none, 01 600h up, 10 400h up, 11 everything
// (RULE6) array writes blocked only by guard range and clear latch
// (RULE7) with latch clear, array and status are unwritable
// (RULE8) pin enable zero makes the lock pin ignored
// (RULE9) pin enable one and lock pin low refuses status writes
// (RULE10) write opcode, two address bytes, low 11 bits used
// (RULE11) address increments per byte, wrapping 7FFh to 0000h
// (RULE12) each data byte committed after its eighth clock, no page limit
// (RULE13) write data taken most significant bit first
// (RULE14) select rising ends a memory write
// (RULE15) read ignores input, shifts out msb first, eight clocks a byte
// (RULE16) select rising ends a memory read
// (RULE17) pause pin low with clock low suspends the operation
// (RULE18) pause pin high resumes; clocks during pause ignored
// (RULE19) master changes pause pin only with clock low
// (RULE20) six opcodes; any other value is no command
// (RULE21) input sampled on clock rise, output driven on clock fall
// (RULE22) status write clears latch at end, data cannot alter latch
// (RULE23) master raises select between opcodes
// (RULE24) bytes to guarded addresses dropped, address still advances
`timescale 1ns/1ps
`default_nettype none
module sfap_fram_access (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // serial pins
   input wire logic spiSck,
   input wire logic spiCsN,
   input wire logic spiMosi,
   input wire logic holdN,
   input wire logic lockPinN,
   output logic spiMiso,
   output logic spiMisoOe,
   // state view
   output logic [7:0] statusView
);
   import sfap_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisation and edge finding
   // ----------------------------------------------------------------
   sfap_pins_t pinsRaw;
   sfap_pins_t pins;
   assign pinsRaw = '{sck: spiSck, csN: spiCsN, mosi: spiMosi, holdN: holdN, lockN: lockPinN};

   sfap_sync uSync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pinsIn(pinsRaw),
      .pinsOut(pins)
   );

   logic sckPrev_q;
   logic csPrev_q;
   logic paused_q;
   // previous levels for edge detection
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sckPrev_q <= 1'b0;
         csPrev_q <= 1'b1;
      end else begin
         sckPrev_q <= pins.sck;
         csPrev_q <= pins.csN;
      end
   end

   // pause tracks hold pin while clock is low, cleared while deselected
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         paused_q <= 1'b0;
      end else if (pins.csN) begin
         paused_q <= 1'b0;
      end else if (!pins.sck) begin
         paused_q <= !pins.holdN; // [RULE17] [RULE18]
      end
   end

   logic sckRise;
   logic sckFall;
   logic csRise;
   logic active;
   assign active = !pins.csN && !paused_q; // [RULE18]
   assign sckRise = active && pins.sck && !sckPrev_q; // [RULE21]
   assign sckFall = active && !pins.sck && sckPrev_q; // [RULE21]
   assign csRise = pins.csN && !csPrev_q;

   // ----------------------------------------------------------------
   // protection decode
   // ----------------------------------------------------------------
   function automatic logic guarded(input logic [1:0] g, input logic [10:0] a); // [RULE5]
      case (g)
         2'h0: guarded = 1'b0;
         2'h1: guarded = (a >= GUARD_QTR_BASE);
         2'h2: guarded = (a >= GUARD_HALF_BASE);
         default: guarded = (a >= GUARD_ALL_BASE);
      endcase
   endfunction : guarded

   // ----------------------------------------------------------------
   // frame state
   // ----------------------------------------------------------------
   sfap_state_t state_q;
   logic [2:0] bitCnt_q;
   logic [7:0] shiftIn_q;
   logic [7:0] opcode_q;
   logic [10:0] addr_q;
   logic [7:0] shiftOut_q;
   logic wroteSomething_q;
   logic latch_q;
   sfap_nv_t nv_q;
   logic [7:0] mem_q [DEPTH];

   logic [7:0] inByte;
   logic byteDone;
   logic isRead;
   logic isWrite;
   assign inByte = {shiftIn_q[6:0], pins.mosi}; // [RULE13]
   assign byteDone = sckRise && (bitCnt_q == BIT_LAST);
   assign isRead = (opcode_q == OP_MEM_READ);
   assign isWrite = (opcode_q == OP_MEM_WRITE);

   logic [7:0] statusByte;
   // zero bits fixed, latch and nonvolatile bits placed
   always_comb begin
      statusByte = 8'h00; // [RULE1]
      statusByte[STAT_PIN_EN_BIT] = nv_q.pinEnable; // [RULE2]
      statusByte[STAT_GUARD_HI_BIT] = nv_q.guardHi;
      statusByte[STAT_GUARD_LO_BIT] = nv_q.guardLo;
      statusByte[STAT_LATCH_BIT] = latch_q;
   end

   logic statusAllowed;
   assign statusAllowed = latch_q && (!nv_q.pinEnable || pins.lockN); // [RULE7] [RULE8] [RULE9]

   logic memCommit;
   assign memCommit = (state_q == ST_DATA) && isWrite && byteDone && latch_q
      && !guarded({nv_q.guardHi, nv_q.guardLo}, addr_q); // [RULE6] [RULE12] [RULE24]

   logic statusCommit;
   assign statusCommit = (state_q == ST_STATUS) && (opcode_q == OP_STATUS_WRITE) && byteDone && statusAllowed;

   // bit counter and input shifter
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bitCnt_q <= 3'h0;
         shiftIn_q <= 8'h00;
      end else if (pins.csN) begin
         bitCnt_q <= 3'h0;
      end else if (sckRise) begin
         bitCnt_q <= bitCnt_q + 3'h1;
         shiftIn_q <= inByte;
      end
   end

   // command sequencing
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_OPCODE;
         opcode_q <= 8'h00;
      end else if (pins.csN) begin
         state_q <= ST_OPCODE; // [RULE14] [RULE16]
      end else if (byteDone) begin
         case (state_q)
            ST_OPCODE: begin
               opcode_q <= inByte;
               case (inByte) // [RULE20]
                  OP_MEM_READ, OP_MEM_WRITE: state_q <= ST_ADDR_HI; // [RULE10]
                  OP_STATUS_READ, OP_STATUS_WRITE: state_q <= ST_STATUS;
                  default: state_q <= ST_IGNORE;
               endcase
            end
            ST_ADDR_HI: state_q <= ST_ADDR_LO;
            ST_ADDR_LO: state_q <= ST_DATA;
            ST_STATUS: state_q <= ST_IGNORE;
            ST_DATA: state_q <= ST_DATA;
            ST_IGNORE: state_q <= ST_IGNORE;
            default: state_q <= ST_IGNORE;
         endcase
      end
   end

   // address capture and increment
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         addr_q <= ADDR_ZERO;
      end else if (byteDone) begin
         if (state_q == ST_ADDR_HI) begin
            addr_q <= {inByte[2:0], addr_q[7:0]}; // [RULE10]
         end else if (state_q == ST_ADDR_LO) begin
            addr_q <= {addr_q[10:8], inByte};
         end else if (state_q == ST_DATA) begin
            addr_q <= addr_q + 11'h001; // [RULE11] [RULE24]
         end
      end
   end

   // write latch, frame-wide write record
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         latch_q <= 1'b0;
         wroteSomething_q <= 1'b0;
      end else if (csRise) begin
         if (wroteSomething_q) begin
            latch_q <= 1'b0; // [RULE4] [RULE22]
         end
         wroteSomething_q <= 1'b0;
      end else if (byteDone && state_q == ST_OPCODE) begin
         if (inByte == OP_WRITE_UNLOCK) begin
            latch_q <= 1'b1; // [RULE4]
         end else if (inByte == OP_WRITE_LOCK) begin
            latch_q <= 1'b0; // [RULE4]
         end
      end else if (memCommit || statusCommit) begin
         wroteSomething_q <= 1'b1;
      end
   end

   // nonvolatile protection bits; latch bit untouched by the byte
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         nv_q <= NV_RESET; // [RULE3]
      end else if (statusCommit) begin
         nv_q.pinEnable <= inByte[STAT_PIN_EN_BIT]; // [RULE22]
         nv_q.guardHi <= inByte[STAT_GUARD_HI_BIT];
         nv_q.guardLo <= inByte[STAT_GUARD_LO_BIT];
      end
   end

   // array storage, held through reset
   always_ff @(posedge clk_sys) begin
      if (memCommit) begin
         mem_q[addr_q] <= inByte; // [RULE12] [RULE13]
      end
   end

   // ----------------------------------------------------------------
   // output shifter
   // ----------------------------------------------------------------
   logic loadRead;
   logic loadStatus;
   assign loadRead = byteDone && isRead && (state_q == ST_ADDR_LO || state_q == ST_DATA);
   assign loadStatus = byteDone && state_q == ST_OPCODE && inByte == OP_STATUS_READ;

   logic [10:0] readAddr;
   assign readAddr = (state_q == ST_ADDR_LO) ? {addr_q[10:8], inByte} : addr_q + 11'h001;

   logic [7:0] pending_q;
   logic sending_q;
   // load on last rise, present msb on following falls
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pending_q <= 8'h00;
         shiftOut_q <= 8'h00;
         sending_q <= 1'b0;
      end else if (pins.csN) begin
         sending_q <= 1'b0;
      end else if (loadRead) begin
         pending_q <= mem_q[readAddr]; // [RULE11] [RULE15]
         sending_q <= 1'b1;
      end else if (loadStatus) begin
         pending_q <= statusByte;
         sending_q <= 1'b1;
      end else if (byteDone && state_q == ST_STATUS) begin
         sending_q <= 1'b0;
      end else if (sckFall && sending_q) begin
         if (bitCnt_q == 3'h0) begin
            shiftOut_q <= pending_q;
         end else begin
            shiftOut_q <= {shiftOut_q[6:0], 1'b0};
         end
      end
   end

   // serial output pin, released when deselected or paused
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         spiMiso <= 1'b0;
         spiMisoOe <= 1'b0;
      end else begin
         spiMisoOe <= active && sending_q;
         if (sckFall && sending_q) begin
            spiMiso <= (bitCnt_q == 3'h0) ? pending_q[7] : shiftOut_q[6]; // [RULE15] [RULE21]
         end
      end
   end

   // registered status view
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         statusView <= 8'h00;
      end else begin
         statusView <= statusByte;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence unlockSeen_s;
      byteDone && state_q == ST_OPCODE && inByte == OP_WRITE_UNLOCK;
   endsequence
   sequence lockSeen_s;
      byteDone && state_q == ST_OPCODE && inByte == OP_WRITE_LOCK;
   endsequence

   zero_bits_a: assert property (@(posedge clk_sys) disable iff (sys_rst) (statusView & 8'h71) == 8'h00) // [RULE1]
      else $error("fixed status bits not zero");
   unlock_sets_a: assert property (@(posedge clk_sys) disable iff (sys_rst) unlockSeen_s |=> latch_q) // [RULE4]
      else $error("unlock did not set latch");
   lock_clears_a: assert property (@(posedge clk_sys) disable iff (sys_rst) lockSeen_s |=> !latch_q) // [RULE4]
      else $error("lock did not clear latch");
   no_latch_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !latch_q |-> !memCommit && !statusCommit) // [RULE7]
      else $error("write without latch");
   guard_block_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE5]
      memCommit |-> (nv_q.guardHi ? (!nv_q.guardLo && addr_q < GUARD_HALF_BASE)
         : (!nv_q.guardLo || addr_q < GUARD_QTR_BASE)))
      else $error("write into guarded range");
   status_lock_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE7]
      !latch_q |=> $stable(nv_q))
      else $error("status changed without latch");
   release_oe_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE16] [RULE17]
      pins.csN || paused_q |=> !spiMisoOe)
      else $error("output driven while released");
   pin_lock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      nv_q.pinEnable && !pins.lockN |=> $stable(nv_q) || $past(pins.lockN)) // [RULE9]
      else $error("status changed while pin locked");
   addr_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      byteDone && state_q == ST_DATA && !pins.csN |=> addr_q == $past(addr_q) + 11'h001) // [RULE11]
      else $error("address did not advance");
   frame_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      csRise |=> state_q == ST_OPCODE && !sending_q) // [RULE14] [RULE16]
      else $error("frame not ended by select");
   pause_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      paused_q && !pins.csN |=> $stable(bitCnt_q)) // [RULE18]
      else $error("count moved while paused");
   latch_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      csRise && wroteSomething_q |=> !latch_q) // [RULE22]
      else $error("latch kept after write");
endmodule : sfap_fram_access
`default_nettype wire

// *** test/sfap_spi_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bus master model, clock stands still outside frames
// ----------------------------------------------------------------
module sfap_spi_master #(parameter time HALF = 100ns) (
   // serial pins
   output var logic sck,
   output var logic csN,
   output var logic mosi,
   output var logic holdN,
   input wire logic miso
);
   // idle levels
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      mosi = 1'b0;
      holdN = 1'b1;
   end
   // select low, mode 3 parks the clock high first
   task automatic open(input logic mode3);
      sck = mode3;
      #(HALF) csN = 1'b0;
      #(HALF);
   endtask : open
   // one byte each way, msb first; pause before bit pz
   task automatic xfer(input logic [7:0] tx, input int pz, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         mosi = tx[i];
         if (i == pz) begin
            holdN = 1'b0; // only while sck low
            repeat (4) #(HALF) sck = ~sck;
            #(HALF) holdN = 1'b1;
            #(HALF); // output enable returns before the next rise
         end
         #(HALF) sck = 1'b1;
         rx[i] = miso; // taken on the rise
         #(HALF);
      end
   endtask : xfer
   // select high after each command
   task automatic close(input logic mode3);
      if (!mode3) sck = 1'b0;
      #(HALF) csN = 1'b1;
      mosi = ~mosi; // released line shows no stale value
      #(2 * HALF);
   endtask : close
endmodule : sfap_spi_master
`default_nettype wire

// *** test/tb_spi_fram_access_protect.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("unexpected at %0t: %h not %h", $time, a, b); end end
module tb_spi_fram_access_protect;
   import sfap_pkg::*;
   // ----------------------------------------------------------------
   // signals and reference state
   // ----------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic lockPinN = 1'b1;
   wire logic sck, csN, mosi, holdN, miso, misoOe, misoBus;
   wire logic [7:0] statusView;
   logic [7:0] sr = 8'h00;
   logic [7:0] mem [DEPTH];
   logic known [DEPTH];
   logic [31:0] seed = 32'h8ECC3B2A;
   logic md;
   int num_errors = 0;
   int n_tests = 0;
   // 40 MHz system clock
   always #12.5ns clk_sys = ~clk_sys;
   // released output line shows the opposite of its last bit
   assign misoBus = misoOe ? miso : ~miso;
   sfap_spi_master m (.sck(sck), .csN(csN), .mosi(mosi), .holdN(holdN), .miso(misoBus));
   sfap_fram_access dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .spiSck(sck), .spiCsN(csN), .spiMosi(mosi),
      .holdN(holdN), .lockPinN(lockPinN), .spiMiso(miso), .spiMisoOe(misoOe), .statusView(statusView));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // xorshift source
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   // guarded range per guard bits
   function automatic logic guarded(input logic [10:0] a, input logic [1:0] g);
      case (g)
         2'h0: return 1'b0;
         2'h1: return a >= GUARD_QTR_BASE;
         2'h2: return a >= GUARD_HALF_BASE;
         default: return 1'b1;
      endcase
   endfunction : guarded
   // verdict and end of run
   task automatic give_verdict();
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   // lock pin, driven just after the clock edge
   task automatic setLock(input logic v);
      @(posedge clk_sys);
      #1 lockPinN = v;
   endtask : setLock
   // opcode frame with one trailing byte when n is above zero
   task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n, output logic [7:0] rx);
      logic [7:0] r;
      r = rnd();
      md = r[0];
      m.open(md);
      m.xfer(op, -1, r);
      if (n > 0) m.xfer(d, -1, rx);
      m.close(md);
   endtask : cmd
   // status read against the reference
   task automatic chkSr();
      logic [7:0] r;
      cmd(OP_STATUS_READ, 8'h00, 1, r);
      `CHK(r, sr)
      `CHK(statusView, sr)
      `CHK(misoOe, 1'b0)
   endtask : chkSr
   // unlock
   task automatic wen();
      logic [7:0] r;
      cmd(OP_WRITE_UNLOCK, 8'h00, 0, r); // unlock ahead of writes
      sr[STAT_LATCH_BIT] = 1'b1;
   endtask : wen
   // status write, reference follows the lock rules
   task automatic wrs(input logic [7:0] v);
      logic [7:0] r;
      cmd(OP_STATUS_WRITE, v, 1, r);
      if (sr[1] && (!sr[7] || lockPinN)) sr = v & STAT_WRITE_MASK;
   endtask : wrs
   // memory burst, pauses inside the second data byte
   task automatic burst(input logic wr, input logic [10:0] a, input int n);
      logic [7:0] r, d, rv;
      logic [10:0] p;
      logic cm;
      cm = 1'b0;
      rv = rnd();
      md = rv[0];
      m.open(md);
      m.xfer(wr ? OP_MEM_WRITE : OP_MEM_READ, -1, r);
      m.xfer({rv[7:3], a[10:8]}, -1, r); // top bits ignored
      m.xfer(a[7:0], -1, r);
      for (int i = 0; i < n; i++) begin
         p = a + i[10:0]; // wraps at the top
         d = rnd();
         m.xfer(d, (i == 1) ? 3 : -1, r);
         if (wr && sr[1] && !guarded(p, sr[3:2])) begin
            mem[p] = d;
            known[p] = 1'b1;
            cm = 1'b1;
         end
         if (!wr && known[p]) `CHK(r, mem[p])
      end
      m.close(md);
      if (cm) sr[STAT_LATCH_BIT] = 1'b0;
   endtask : burst
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] r;
      foreach (known[i]) known[i] = 1'b0;
      repeat (10) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chkSr(); // cleared guards and latch
      // unknown opcodes leave the latch alone
      cmd(8'hFF, 8'h00, 0, r);
      wen();
      cmd(8'h07, 8'h00, 0, r);
      chkSr();
      cmd(OP_WRITE_LOCK, 8'h00, 0, r);
      sr[STAT_LATCH_BIT] = 1'b0;
      chkSr();
      // wrapping burst, then writes with the latch clear
      wen();
      burst(1'b1, 11'h7FC, 8);
      chkSr(); // write ended by select rise
      burst(1'b0, 11'h7FC, 8);
      burst(1'b1, 11'h7FC, 8);
      burst(1'b0, 11'h7FC, 8); // refused bytes
      chkSr(); // read ended by select rise
      // every guard setting, lock pin ignored with pin enable clear
      for (int g = 0; g < 4; g++) begin
         r = rnd();
         setLock(r[0]);
         wen();
         wrs({4'h7, g[1:0], 2'h3});
         chkSr();
         for (int k = 0; k < 3; k++) begin
            wen();
            burst(1'b1, 11'h3FE + 11'h200 * k[10:0], 4);
            burst(1'b0, 11'h3FE + 11'h200 * k[10:0], 4);
         end
      end
      setLock(1'b1);
      wen();
      wrs(8'h80);
      chkSr();
      // pin enable set, lock low: status refused, array open
      setLock(1'b0);
      wen();
      wrs(8'h8C);
      chkSr();
      burst(1'b1, 11'h100, 3);
      burst(1'b0, 11'h100, 3);
      setLock(1'b1);
      wen();
      wrs(8'h00);
      chkSr();
      give_verdict();
   end
   // watchdog
   initial begin
      repeat (100000) @(posedge clk_sys);
      num_errors++;
      give_verdict();
   end
endmodule : tb_spi_fram_access_protect
`default_nettype wire
